// file: logic/dio_pkg.sv
// Package with constants and carriers for the digital I/O port controller
package dio_pkg;

  localparam int NUM_PORTS = 8;
  localparam int PORT_WIDTH = 8;

  // Reference voltage selections
  typedef enum logic [2:0] {
    REF_NONE,
    REF_3V3,
    REF_5V,
    REF_12V,
    REF_24V,
    REF_USER,
    REF_LV_EMU,
    REF_TTL_EMU
  } ref_sel_t;

  // Timing of the over-current filter
  localparam int CLK_FREQ_HZ = 20_000_000;
  localparam real OC_FILTER_US = 12.8;
  localparam real OC_SHUTOFF_US = 20.0;
  // Least time: fault must persist strictly longer, so round up
  localparam int OC_FILTER_CYCLES = int'($ceil(OC_FILTER_US * CLK_FREQ_HZ / 1.0E6));
  // Longest time: round down
  localparam int OC_SHUTOFF_CYCLES = int'($floor(OC_SHUTOFF_US * CLK_FREQ_HZ / 1.0E6));

  // Reset values
  localparam logic [7:0] OUT_DATA_RESET = 8'hFF;
  localparam logic PORT_DIR_RESET = 1'h0;
  localparam logic PORT_POL_RESET = 1'h0;

  // Per-port configuration carried together
  typedef struct packed {
    logic dir_out;
    logic pol_rev;
    ref_sel_t ref_sel;
  } port_cfg_t;

  // Per-port pull-up and reference enables toward the analog switches
  typedef struct packed {
    logic weak_pullup;
    logic lv_pullup;
    logic ttl_pullup;
    ref_sel_t ref_sel;
  } port_analog_t;

endpackage

// file: logic/oc_filter.sv
// Over-current filter and latched fault flag for one port
`timescale 1ns/100ps
module oc_filter
  import dio_pkg::*;
#(
  parameter int FILTER_CYCLES = OC_FILTER_CYCLES
)
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Fault sense and software clear
  input wire logic sense,
  input wire logic clear,
  // Latched fault
  output logic fault
);

  localparam int CW = $clog2(FILTER_CYCLES + 2);

  // A zero filter would trip on one sensed edge
  if (FILTER_CYCLES < 1)
  begin : g_bad_filter
    $error("FILTER_CYCLES must be at least 1");
  end

  logic [CW-1:0] run_count;

  // Count consecutive sensed cycles; any gap restarts the filter
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst || !sense || clear)
    begin
      run_count <= '0;
    end
    else if (!fault && run_count <= CW'(FILTER_CYCLES))
    begin
      run_count <= run_count + CW'(1);
    end
  end

  // Trip once persistence exceeds the filter time; set wins over clear
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      fault <= 1'b0;
    end
    else if (sense && !fault && run_count >= CW'(FILTER_CYCLES))
    begin
      fault <= 1'b1;
    end
    else if (clear)
    begin
      fault <= 1'b0;
    end
  end

endmodule // oc_filter

// file: logic/dio_port_overcurrent_ctrl.sv
// Eight-port digital I/O controller with per-port over-current protection
`timescale 1ns/100ps
module dio_port_overcurrent_ctrl
  import dio_pkg::*;
#(
  parameter int NPORTS = NUM_PORTS,
  parameter int FILTER_CYCLES = OC_FILTER_CYCLES
)
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Software configuration writes
  input wire logic cfg_wr,
  input wire logic [2:0] cfg_port,
  input wire port_cfg_t cfg_data,
  // Software data writes
  input wire logic data_wr,
  input wire logic [2:0] data_port,
  input wire logic [7:0] data_value,
  // Software over-current clear, one bit per port
  input wire logic [NPORTS-1:0] oc_clear,
  // Channel sensing
  input wire logic [NPORTS*8-1:0] line_above_upper_input_threshold,
  input wire logic [NPORTS*8-1:0] line_below_lower_input_threshold,
  input wire logic [NPORTS*8-1:0] channel_overcurrent,
  // Channel drive and analog switches
  output logic [NPORTS*8-1:0] pulldown_on,
  output port_analog_t [NPORTS-1:0] port_reference_voltage,
  // Status toward software
  output logic [NPORTS*8-1:0] read_data,
  output logic [NPORTS-1:0] oc_status,
  output port_cfg_t [NPORTS-1:0] cfg_status,
  output logic cfg_refused
);

  // Port index is three bits wide, so no more than eight ports can be addressed
  if (NPORTS < 1 || NPORTS > 8)
  begin : g_bad_nports
    $error("NPORTS must be 1 to 8");
  end

  // A zero filter would trip on a single sensed edge and defeat the transient guard
  if (FILTER_CYCLES < 1)
  begin : g_bad_filter
    $error("FILTER_CYCLES must be at least 1");
  end

  // Emulation selections need output direction
  function automatic logic is_emu(input ref_sel_t s);
    return (s == REF_LV_EMU) || (s == REF_TTL_EMU);
  endfunction

  // Address decode shared by the configuration and data strobes
  function automatic logic port_hit(input logic strobe, input logic [2:0] idx, input int p);
    return strobe && (idx == 3'(p));
  endfunction

  // Per-port state; out_data keeps logical data, polarity is applied on the way out
  port_cfg_t [NPORTS-1:0] cfg;
  logic [NPORTS-1:0][7:0] out_data;
  logic [NPORTS-1:0] oc_fault_vec;

  // Refuse input direction together with emulation
  assign cfg_refused = cfg_wr && is_emu(cfg_data.ref_sel) && !cfg_data.dir_out;

  // Status views are the live registers, no extra copy
  assign cfg_status = cfg;
  assign oc_status = oc_fault_vec;

  genvar p;
  generate
    for (p = 0; p < NPORTS; p++)
    begin : g_port
      logic hit_cfg;
      logic hit_data;
      logic any_oc;
      logic [7:0] drive_bits;
      logic [7:0] hyst;

      // Strobe decode; a refused configuration touches no port
      assign hit_cfg = port_hit(cfg_wr, cfg_port, p) && !cfg_refused;
      assign hit_data = port_hit(data_wr, data_port, p);
      // One sensed channel is enough to start the port filter
      assign any_oc = |channel_overcurrent[p*8 +: 8];

      // Port configuration register
      always_ff @(posedge ref_clk)
      begin
        if (sys_rst)
        begin
          cfg[p] <= '{dir_out: PORT_DIR_RESET, pol_rev: PORT_POL_RESET,
                      ref_sel: REF_NONE};
        end
        else if (hit_cfg)
        begin
          cfg[p] <= cfg_data;
        end
      end

      // Output data register, kept across faults so recovery restores it
      always_ff @(posedge ref_clk)
      begin
        if (sys_rst)
        begin
          out_data[p] <= OUT_DATA_RESET;
        end
        else if (hit_cfg && (cfg_data.ref_sel != cfg[p].ref_sel ||
                 (is_emu(cfg[p].ref_sel) && cfg_data.dir_out != cfg[p].dir_out)))
        begin
          out_data[p] <= OUT_DATA_RESET;
        end
        else if (hit_data && cfg[p].dir_out)
        begin
          // Stored as written, so a later polarity change flips the lines
          out_data[p] <= data_value;
        end
      end

      oc_filter #(
        .FILTER_CYCLES(FILTER_CYCLES)
      ) u_oc (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .sense(any_oc),
        .clear(oc_clear[p]),
        .fault(oc_fault_vec[p])
      );

      // Polarity applied at the driver, so it acts on data already stored
      assign drive_bits = out_data[p] ^ {8{cfg[p].pol_rev}};

      // Pull-down drive; a fault or input direction releases the whole port
      always_ff @(posedge ref_clk)
      begin
        if (sys_rst || !cfg[p].dir_out || oc_fault_vec[p])
        begin
          pulldown_on[p*8 +: 8] <= 8'h00;
        end
        else
        begin
          pulldown_on[p*8 +: 8] <= ~drive_bits;
        end
      end

      // Pull-up selection follows the reference setting
      always_ff @(posedge ref_clk)
      begin
        if (sys_rst)
        begin
          port_reference_voltage[p] <= '{weak_pullup: 1'b1, lv_pullup: 1'b0,
                                         ttl_pullup: 1'b0, ref_sel: REF_NONE};
        end
        else
        begin
          port_reference_voltage[p].ref_sel <= cfg[p].ref_sel;
          port_reference_voltage[p].lv_pullup <= cfg[p].ref_sel == REF_LV_EMU;
          port_reference_voltage[p].ttl_pullup <= cfg[p].ref_sel == REF_TTL_EMU;
          port_reference_voltage[p].weak_pullup <= !is_emu(cfg[p].ref_sel);
        end
      end

      // Hysteresis: hold state between thresholds
      // Upper comparator wins if both fire; lines idle high on the weak pull-up
      always_ff @(posedge ref_clk)
      begin
        if (sys_rst)
        begin
          hyst <= 8'hFF;
        end
        else
        begin
          for (int b = 0; b < 8; b++)
          begin
            if (line_above_upper_input_threshold[p*8+b])
            begin
              hyst[b] <= 1'b1;
            end
            else if (line_below_lower_input_threshold[p*8+b])
            begin
              hyst[b] <= 1'b0;
            end
          end
        end
      end

      // Read data reflects the pins with polarity applied
      always_ff @(posedge ref_clk)
      begin
        if (sys_rst)
        begin
          read_data[p*8 +: 8] <= 8'hFF;
        end
        else
        begin
          read_data[p*8 +: 8] <= hyst ^ {8{cfg[p].pol_rev}};
        end
      end
    end
  endgenerate

endmodule // dio_port_overcurrent_ctrl

// file: test/dio_asserts.sv
// Assertions for the I/O controller: port 0, plus configuration refusal across all ports
`timescale 1ns/100ps
module dio_asserts
  import dio_pkg::*;
#(parameter int NPORTS = NUM_PORTS, parameter int FILTER_CYCLES = OC_FILTER_CYCLES)
(
  // Clock, reset and requests
  input logic ref_clk,
  input logic sys_rst,
  input logic cfg_wr,
  input port_cfg_t cfg_data,
  input logic [NPORTS-1:0] oc_clear,
  input logic [NPORTS*8-1:0] channel_overcurrent,
  // Watched outputs
  input logic [NPORTS*8-1:0] pulldown_on,
  input port_analog_t [NPORTS-1:0] port_reference_voltage,
  input logic [NPORTS-1:0] oc_status,
  input port_cfg_t [NPORTS-1:0] cfg_status,
  input logic cfg_refused
);
  localparam int SHUT_MAX = 400;
  logic [9:0] cnt;
  logic sense;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  // Run length of sense; saturates so it never wraps
  assign sense = |channel_overcurrent[7:0];
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst || !sense)
      cnt <= 10'h000;
    else if (cnt != 10'h3FF)
      cnt <= cnt + 10'h001;
  end
  // Fault held over two edges
  sequence s_off_two;
    oc_status[0] ##1 oc_status[0];
  endsequence
  // Drive register lags the direction by one edge
  a_input_no_pulldown: assert property (!$past(cfg_status[0].dir_out) |->
    pulldown_on[7:0] == 8'h00)
    else $error("input port pull-down on");
  a_fault_port_off: assert property (s_off_two |-> pulldown_on[7:0] == 8'h00)
    else $error("faulted port still driving");
  a_filter_min_time: assert property ($rose(oc_status[0]) |-> cnt >= FILTER_CYCLES)
    else $error("fault taken too early");
  a_shutoff_bound: assert property ($rose(sense) |->
    ##[0:SHUT_MAX] (pulldown_on[7:0] == 8'h00 || !sense))
    else $error("port not switched off in time");
  a_flag_latched: assert property (oc_status[0] && !oc_clear[0] |=> oc_status[0])
    else $error("fault flag dropped");
  a_clear_drops_flag: assert property (oc_clear[0] && oc_status[0] && !sense |=> !oc_status[0])
    else $error("clear ignored");
  a_refuse_cause: assert property (cfg_wr && !cfg_data.dir_out &&
    cfg_data.ref_sel inside {REF_LV_EMU, REF_TTL_EMU} |-> cfg_refused)
    else $error("emulated input not refused");
  a_refused_kept: assert property (cfg_refused |=> $stable(cfg_status))
    else $error("refused config applied");
  a_pullup_match: assert property (
    port_reference_voltage[0].weak_pullup !=
    ($past(cfg_status[0].ref_sel) inside {REF_LV_EMU, REF_TTL_EMU}) &&
    port_reference_voltage[0].lv_pullup == ($past(cfg_status[0].ref_sel) == REF_LV_EMU) &&
    port_reference_voltage[0].ttl_pullup == ($past(cfg_status[0].ref_sel) == REF_TTL_EMU))
    else $error("pull-up choice wrong");
endmodule // dio_asserts
bind dio_port_overcurrent_ctrl dio_asserts #(.NPORTS(NPORTS), .FILTER_CYCLES(FILTER_CYCLES))
  u_chk (.ref_clk, .sys_rst, .cfg_wr, .cfg_data, .oc_clear, .channel_overcurrent,
  .pulldown_on, .port_reference_voltage, .oc_status, .cfg_status, .cfg_refused);

// file: test/dio_loads.sv
// Loads and sources on the channels, seen through comparators
`timescale 1ns/100ps
module dio_loads
(
  // Card drive and scenario controls
  input logic [63:0] pulldown_on,
  input logic [63:0] src_low,
  input logic [63:0] src_mid,
  input logic [63:0] shorted,
  // Comparators and current sense
  output logic [63:0] above,
  output logic [63:0] below,
  output logic [63:0] sense
);
  // Mid-band lines sit between thresholds, so neither comparator fires
  assign below = (pulldown_on | src_low) & ~src_mid;
  assign above = ~(pulldown_on | src_low | src_mid);
  // Current only flows while the pull-down conducts into a short
  assign sense = pulldown_on & shorted;
endmodule // dio_loads

// file: test/dio_port_overcurrent_ctrl_tb.sv
// Directed bench for the eight-port I/O controller
`timescale 1ns/100ps
module dio_port_overcurrent_ctrl_tb;
  import dio_pkg::*;
  localparam int FC = 4;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic cfg_wr = 1'b0;
  logic data_wr = 1'b0;
  logic seen = 1'b0;
  logic refused;
  logic [2:0] cfg_port = 3'h0;
  logic [2:0] data_port = 3'h0;
  logic [7:0] data_value = 8'h00;
  logic [7:0] oc_clear = 8'h00;
  logic [7:0] ocs;
  logic [63:0] up, dn, sense, pd, rd, lo = '0, mid = '0, shorted = '0;
  port_cfg_t cfg_data = '0;
  port_cfg_t [7:0] cs;
  port_analog_t [7:0] prv;
  int err_total = 0;
  int comparisons = 0;
  int n;
  // 20 MHz clock
  initial
  begin
    forever #25 ref_clk = ~ref_clk;
  end
  dio_port_overcurrent_ctrl #(.FILTER_CYCLES(FC)) dut (.ref_clk, .sys_rst, .cfg_wr, .cfg_port,
    .cfg_data, .data_wr, .data_port, .data_value, .oc_clear,
    .line_above_upper_input_threshold(up), .line_below_lower_input_threshold(dn),
    .channel_overcurrent(sense), .pulldown_on(pd), .port_reference_voltage(prv),
    .read_data(rd), .oc_status(ocs), .cfg_status(cs), .cfg_refused(refused));
  dio_loads loads (.pulldown_on(pd), .src_low(lo), .src_mid(mid), .shorted, .above(up),
    .below(dn), .sense);
  // Inputs move 1 ns after the edge so nothing races the sampling
  task automatic cyc(input int k);
    repeat (k) @(posedge ref_clk);
    #1;
  endtask
  task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
    comparisons++;
    if (g !== e)
    begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic cfg(input logic [2:0] p, input port_cfg_t d);
    cfg_wr = 1'b1;
    cfg_port = p;
    cfg_data = d;
    #1 seen = refused;
    cyc(1);
    cfg_wr = 1'b0;
    // Idle edge so a following call never re-raises the strobe in this step
    cyc(1);
  endtask
  task automatic wr(input logic [2:0] p, input logic [7:0] v);
    data_wr = 1'b1;
    data_port = p;
    data_value = v;
    cyc(1);
    data_wr = 1'b0;
    // Idle edge so a following call never re-raises the strobe in this step
    cyc(1);
  endtask
  task automatic t_reset;
    chk("cfg", 64'h0, cs);
    chk("pd", 64'h0, pd);
    chk("rd", '1, rd);
    $display("reset test done");
  endtask
  // Port 2 driven, input port 5 written in passing
  task automatic t_drive;
    cfg(3'h2, '{1'b1, 1'b0, REF_12V});
    chk("pd ones", 64'h0, pd);
    wr(3'h2, 8'hA5);
    wr(3'h5, 8'h00);
    chk("pd", 64'h5A << 16, pd);
    cyc(2);
    chk("rd", ~(64'h5A << 16), rd);
    cfg(3'h2, '{1'b1, 1'b1, REF_12V});
    cyc(2);
    chk("pd flip", 64'hA5 << 16, pd);
    chk("rd rev", ~(64'h5A << 16), rd);
    wr(3'h2, 8'h0F);
    cyc(1);
    chk("pd rev", 64'h0F << 16, pd);
    cfg(3'h2, '{1'b1, 1'b0, REF_24V});
    chk("pd new ref", 64'h0, pd);
    $display("drive test done");
  endtask
  // Every reference code, then an emulated input refused
  task automatic t_emul;
    for (int k = 0; k < 8; k++)
    begin
      cfg(3'h0, '{1'b1, 1'b0, ref_sel_t'(k)});
      cyc(1);
      chk("ref", {k < 6, k == 6, k == 7, 3'(k)}, prv[0]);
    end
    cfg(3'h0, '{1'b0, 1'b0, REF_LV_EMU});
    chk("refused", 64'h1, seen);
    chk("cfg kept", 64'h17, cs[0]);
    cfg(3'h0, '{1'b1, 1'b0, REF_5V});
    $display("emulation test done");
  endtask
  // Glitch, sustained fault, latch, clear and restore on port 0
  task automatic t_fault;
    wr(3'h0, 8'hF0);
    shorted[0] = 1'b1;
    cyc(2);
    shorted[0] = 1'b0;
    cyc(FC + 4);
    chk("glitch", 64'h0, ocs);
    shorted[0] = 1'b1;
    n = 0;
    while (ocs[0] !== 1'b1 && n < 400)
    begin
      cyc(1);
      n++;
    end
    chk("trip time", 64'h1, n > FC && n < 400);
    if (n == 400)
      test_done;
    cyc(2);
    chk("port off", 64'h0, pd);
    shorted[0] = 1'b0;
    cyc(FC + 4);
    chk("latched", 64'h1, ocs);
    oc_clear[0] = 1'b1;
    cyc(1);
    oc_clear[0] = 1'b0;
    cyc(1);
    chk("cleared", 64'h0, ocs);
    chk("restored", 64'h0F, pd);
    $display("fault test done");
  endtask
  // Low, mid-band, high, mid-band on input port 5
  task automatic t_hyst;
    lo[40] = 1'b1;
    cyc(3);
    chk("low", 64'hFE, rd[47:40]);
    mid[40] = 1'b1;
    cyc(3);
    chk("mid low", 64'hFE, rd[47:40]);
    lo[40] = 1'b0;
    mid[40] = 1'b0;
    cyc(3);
    chk("high", 64'hFF, rd[47:40]);
    mid[40] = 1'b1;
    cyc(3);
    chk("mid high", 64'hFF, rd[47:40]);
    $display("hysteresis test done");
  endtask
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial
  begin
    cyc(10);
    sys_rst = 1'b0;
    cyc(1);
    t_reset;
    t_drive;
    t_emul;
    t_fault;
    t_hyst;
    test_done;
  end
endmodule // dio_port_overcurrent_ctrl_tb
